//--- verilog/lcd_plane_output_mapper.sv
// Maps the drive mode, RAM and frame timing onto common and segment outputs
`timescale 1ns/1ps
module lcd_plane_output_mapper
   import lcd_map_pkg::*;
#(
   parameter int SLOT_LEN = SLOT_CYCLES
)
(
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire drive_mode_t mode_sel,
   input  wire logic        bank_sel,
   input  wire ram_write_t  ram_wr,
   output logic [2:0]       active_slot,
   output logic             frame_start,
   output drive_mode_t      active_mode,
   output logic [7:0]       common_plane,
   output logic [BASE_COLS-1:0] segment_col,
   output logic             shared_pin_plane6_col45,
   output logic             shared_pin_plane7_col44,
   output logic             shared_pins_are_segments
);

   // Column-major store: ram[col] holds rows 0..7
   logic [7:0]          ram [NUM_COLS];
   logic [7:0]          disp_reg [NUM_COLS];
   drive_mode_t         mode;
   logic                shown_bank;
   logic [2:0]          slot;
   logic                frame_end;
   logic [3:0]          rows;
   logic [7:0]          next_planes;
   logic [NUM_COLS-1:0] next_segs;
   logic [7:0]          wr_mask;
   logic                banked;
   // Delays frame_start until the first outputs of the new frame
   logic                frame_load;

   ////////////////////////////////////////////////////////////////////////
   // Modes whose RAM is split into two banks
   function automatic logic is_banked(input drive_mode_t m);
      unique case (m)
         MODE_STATIC, MODE_MUX2, MODE_MUX4: is_banked = 1'b1;
         MODE_MUX6, MODE_MUX8:              is_banked = 1'b0;
         default:                           is_banked = 1'b0; // Illegal code
      endcase
   endfunction : is_banked

   assign rows   = rows_of(mode);
   assign banked = is_banked(mode);

   lcd_slot_timer #(.SLOT_LEN(SLOT_LEN)) u_timer
   (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .rows      (rows),
      .slot      (slot),
      .frame_end (frame_end)
   );

   ////////////////////////////////////////////////////////////////////////
   // Mode and bank take effect only at frame boundary
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         mode       <= MODE_MUX8;
         shown_bank <= 1'b0;
      end
      else if (frame_end)
      begin
         unique case (mode_sel)
            MODE_STATIC, MODE_MUX2, MODE_MUX4, MODE_MUX6, MODE_MUX8:
               mode <= mode_sel;
            default:
               mode <= mode; // Illegal code keeps current mode
         endcase
         shown_bank <= bank_sel;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // RAM write: row span depends on mode; banked modes put bank 1 in the upper half
   always_comb
   begin
      unique case (mode)
         MODE_STATIC: wr_mask = ram_wr.bank ? 8'h10 : 8'h01;
         MODE_MUX2:   wr_mask = ram_wr.bank ? 8'h30 : 8'h03;
         MODE_MUX4:   wr_mask = ram_wr.bank ? 8'hF0 : 8'h0F;
         MODE_MUX6:   wr_mask = 8'h3F;
         MODE_MUX8:   wr_mask = 8'hFF;
         default:     wr_mask = 8'h00;
      endcase
   end

   // Refused columns drop silently; there is no error flag
   // RAM has no reset, so the host fills it before the first frame end
   always_ff @(posedge core_clk)
   begin
      if (ram_wr.en && (ram_wr.col < ((mode == MODE_MUX6) ? COL_W'(NUM_COLS) : COL_W'(BASE_COLS))))
         ram[ram_wr.col] <= (ram[ram_wr.col] & ~wr_mask) | (ram_wr.data & wr_mask);
   end

   // Snapshot whole RAM each frame so writes never tear the picture
   always_ff @(posedge core_clk)
   begin
      for (int c = 0; c < NUM_COLS; c++)
      begin
         if (!rst_n)
            disp_reg[c] <= 8'h00;
         else if (frame_end)
            disp_reg[c] <= ram[c];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Plane waveform: high marks the selected plane in its slot
   always_comb
   begin
      logic [7:0] sel;
      sel = 8'h01 << slot;
      unique case (mode)
         MODE_MUX8:   next_planes = sel;
         MODE_MUX6:   next_planes = {2'b00, sel[5:0]};
         MODE_MUX4:   next_planes = {sel[3:0], sel[3:0]};
         MODE_MUX2:   next_planes = {4{sel[1:0]}};
         MODE_STATIC: next_planes = 8'hFF;
         default:     next_planes = 8'h00;
      endcase
   end

   // Segment level: bit of active row, offset by four for bank 1 of banked modes
   always_comb
   begin
      logic [2:0] row;
      row = slot;
      // Bank 1 sits in rows 4..7 of each column
      if (banked && shown_bank)
         row = slot + 3'h4;
      for (int c = 0; c < NUM_COLS; c++)
         next_segs[c] = disp_reg[c][row];
      if (mode != MODE_MUX6)
         next_segs[NUM_COLS-1:BASE_COLS] = 2'b00;
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode, bank and snapshot load on the frame_end edge, so the new
   // frame's outputs appear one edge later; frame_start waits for them
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         frame_load <= 1'b0;
      else
         frame_load <= frame_end;
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         frame_start <= 1'b0;
      else
         frame_start <= frame_load;
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered drive outputs
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         common_plane <= PLANES_RESET;
      else
         common_plane <= next_planes;
   end

   // Segments 0-43 drive in every mode
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         segment_col <= '0;
      else
         segment_col <= next_segs[BASE_COLS-1:0];
   end

   // Shared pins: segment data in six-way, plane copies otherwise
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         shared_pin_plane6_col45  <= 1'b0;
         shared_pin_plane7_col44  <= 1'b0;
         shared_pins_are_segments <= 1'b0;
      end
      else if (mode == MODE_MUX6)
      begin
         shared_pin_plane6_col45  <= next_segs[45];
         shared_pin_plane7_col44  <= next_segs[44];
         shared_pins_are_segments <= 1'b1;
      end
      else
      begin
         // No segment data leaves these pins outside six-way
         shared_pin_plane6_col45  <= next_planes[6];
         shared_pin_plane7_col44  <= next_planes[7];
         shared_pins_are_segments <= 1'b0;
      end
   end

   // Slot and mode of the frame being shown
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         active_slot <= SLOT_RESET;
         active_mode <= MODE_MUX8;
      end
      else
      begin
         active_slot <= slot;
         active_mode <= mode;
      end
   end

endmodule : lcd_plane_output_mapper

//--- verilog/lcd_map_pkg.sv
// Constants and types for the LCD common-plane and segment output mapper
package lcd_map_pkg;

   localparam int NUM_ROWS     = 8;
   localparam int NUM_COLS     = 46;
   localparam int BASE_COLS    = 44;
   localparam int COL_W        = 6;
   localparam int ROW_W        = 3;
   // Cycles per multiplex time slot at 50 MHz
   localparam int SLOT_TIME_US = 100;
   localparam int CLK_MHZ      = 50;
   localparam int SLOT_CYCLES  = SLOT_TIME_US * CLK_MHZ;
   localparam logic [2:0] SLOT_RESET = 3'h0;
   localparam logic [NUM_ROWS-1:0] PLANES_RESET = 8'h00;

   typedef enum logic [4:0]
   {
      MODE_STATIC = 5'h01,
      MODE_MUX2   = 5'h02,
      MODE_MUX4   = 5'h04,
      MODE_MUX6   = 5'h08,
      MODE_MUX8   = 5'h10
   } drive_mode_t;

   typedef struct packed
   {
      logic             en;
      logic             bank;
      logic [COL_W-1:0] col;
      logic [7:0]       data;
   } ram_write_t;

   typedef struct packed
   {
      logic [NUM_ROWS-1:0] planes;
      logic [NUM_COLS-1:0] segments;
      logic                seg44_45_en;
   } lcd_drive_t;

   // Row count for a mode
   function automatic logic [3:0] rows_of(input drive_mode_t m);
      unique case (m)
         MODE_STATIC: rows_of = 4'h1;
         MODE_MUX2:   rows_of = 4'h2;
         MODE_MUX4:   rows_of = 4'h4;
         MODE_MUX6:   rows_of = 4'h6;
         MODE_MUX8:   rows_of = 4'h8;
         default:     rows_of = 4'h1;
      endcase
   endfunction : rows_of

endpackage : lcd_map_pkg

//--- verilog/lcd_slot_timer.sv
// Time-slot sequencer: steps the active common plane and marks frame ends
`timescale 1ns/1ps
module lcd_slot_timer
   import lcd_map_pkg::*;
#(
   parameter int SLOT_LEN = SLOT_CYCLES
)
(
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic [3:0] rows,
   output logic [2:0]      slot,
   output logic            frame_end
);

   logic [$clog2(SLOT_LEN+1)-1:0] count;
   logic                          slot_end;

   assign slot_end  = (count == ($bits(count))'(SLOT_LEN - 1));
   assign frame_end = slot_end && ({1'b0, slot} + 4'h1 >= rows);

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         count <= '0;
      else if (slot_end)
         count <= '0;
      else
         count <= count + 1'b1;
   end

   // Slot n active means plane n active
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         slot <= SLOT_RESET;
      else if (frame_end)
         slot <= SLOT_RESET;
      else if (slot_end)
         slot <= slot + 3'h1;
   end

endmodule : lcd_slot_timer

//--- dv/lcd_map_checker.sv
// Output relation checker for the plane mapper
`timescale 1ns/1ps
module lcd_map_checker
   import lcd_map_pkg::*;
#(
   parameter int SLOT_LEN = 4
)
(
   input wire logic                 core_clk,
   input wire logic                 rst_n,
   input wire logic                 frame_start,
   input wire drive_mode_t          active_mode,
   input wire logic [2:0]           active_slot,
   input wire logic [7:0]           common_plane,
   input wire logic [BASE_COLS-1:0] segment_col,
   input wire logic                 shared_pins_are_segments
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // Cycles the shown slot has stood, for the slot length check
   logic [15:0] slot_age;
   logic        slot_seen;
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         slot_age  <= 16'h0000;
         slot_seen <= 1'b0;
      end
      else if ($changed(active_slot) || frame_start)
      begin
         slot_age  <= 16'h0000;
         slot_seen <= 1'b1;
      end
      else
         slot_age <= slot_age + 16'h0001;
   end
   slot_length_a: assert property (slot_seen && $changed(active_slot) |->
      slot_age == 16'(SLOT_LEN - 1)) else $error("slot length wrong");
   plane_walk_a: assert property (active_mode == MODE_MUX8 && common_plane != 8'h00 |->
      common_plane == 8'h01 << active_slot) else $error("plane order wrong");
   six_pins_a: assert property (active_mode == MODE_MUX6 |->
      common_plane[7:6] == 2'h0 && shared_pins_are_segments) else $error("six-way pins wrong");
   four_copy_a: assert property (active_mode == MODE_MUX4 |->
      common_plane[7:4] == common_plane[3:0]) else $error("four-way copy wrong");
   two_copy_a: assert property (active_mode == MODE_MUX2 |->
      common_plane == {4{common_plane[1:0]}}) else $error("two-way copy wrong");
   static_copy_a: assert property (active_mode == MODE_STATIC |->
      common_plane == 8'hFF) else $error("static copy wrong");
   pulse_once_a: assert property (frame_start |=> !frame_start) else $error("frame pulse long");
   frame_slot_a: assert property (frame_start |-> active_slot == 3'h0) else $error("frame slot");
   mode_edge_a: assert property ($changed(active_mode) |-> frame_start) else $error("mode mid-frame");
   seg_hold_a: assert property (!frame_start && $stable(active_slot) |->
      $stable(segment_col)) else $error("segments moved in slot");
   mode_legal_a: assert property ($onehot(active_mode)) else $error("mode not one-hot");
   cover property (frame_start && active_mode == MODE_MUX6);
   cover property (frame_start && active_mode == MODE_MUX4);
   cover property (frame_start && active_mode == MODE_STATIC);
   cover property (frame_start && active_mode == MODE_MUX2);
endmodule : lcd_map_checker
bind lcd_plane_output_mapper lcd_map_checker #(.SLOT_LEN(SLOT_LEN)) chk (.core_clk(core_clk), .rst_n(rst_n),
   .frame_start(frame_start), .active_mode(active_mode), .active_slot(active_slot),
   .common_plane(common_plane), .segment_col(segment_col), .shared_pins_are_segments(shared_pins_are_segments));

//--- dv/lcd_glass_model.sv
// Glass model: each element keeps the level seen while its plane is selected
`timescale 1ns/1ps
module lcd_glass_model
   import lcd_map_pkg::*;
(
   input  wire logic                core_clk,
   input  wire logic [NUM_ROWS-1:0] planes,
   input  wire logic [NUM_COLS-1:0] segs,
   output logic [7:0]               pix [NUM_COLS]
);
   always_ff @(posedge core_clk)
      for (int r = 0; r < NUM_ROWS; r++)
         if (planes[r])
            for (int c = 0; c < NUM_COLS; c++)
               pix[c][r] <= segs[c];
endmodule : lcd_glass_model

//--- dv/test_lcd_plane_output_mapper.sv
// Self-checking bench for the plane mapper
`timescale 1ns/1ps
module test_lcd_plane_output_mapper
   import lcd_map_pkg::*;
();
   logic                 core_clk;
   logic                 rst_n;
   drive_mode_t          mode_sel;
   logic                 bank_sel;
   ram_write_t           ram_wr;
   logic                 frame_start;
   logic [7:0]           common_plane;
   logic [BASE_COLS-1:0] segment_col;
   logic                 col45_pin;
   logic                 col44_pin;
   logic                 pins_seg;
   logic [7:0]           pix [NUM_COLS];
   int                   n_fail;
   int                   num_checks;
   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   lcd_plane_output_mapper #(.SLOT_LEN(4)) dut (.core_clk(core_clk), .rst_n(rst_n), .mode_sel(mode_sel),
      .bank_sel(bank_sel), .ram_wr(ram_wr), .active_slot(), .frame_start(frame_start), .active_mode(),
      .common_plane(common_plane), .segment_col(segment_col), .shared_pin_plane6_col45(col45_pin),
      .shared_pin_plane7_col44(col44_pin), .shared_pins_are_segments(pins_seg));
   lcd_glass_model glass (.core_clk(core_clk), .planes(common_plane),
      .segs({col45_pin, col44_pin, segment_col}), .pix(pix));
   ////////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Held across calls so back-to-back writes never pulse en low
   task automatic wr(input logic b, input logic [5:0] c, input logic [7:0] d);
      ram_wr = '{1'b1, b, c, d};
      @(negedge core_clk);
   endtask : wr
   task automatic frame;
      int i;
      i = 0;
      do
      begin
         @(negedge core_clk);
         i++;
      end
      while (frame_start !== 1'b1 && i < 100);
      if (i >= 100)
      begin
         n_fail++;
         test_done();
      end
   endtask : frame
   // Second frame is the first seen whole in the new mode; the check follows the third
   task automatic run(input drive_mode_t m, input logic b, input int rows, input int c, input logic [7:0] e);
      mode_sel = m;
      bank_sel = b;
      repeat (3) frame();
      chk(pix[c] & (8'hFF >> (8 - rows)), e);
   endtask : run
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      n_fail = 0;
      num_checks = 0;
      rst_n = 1'b0;
      mode_sel = MODE_MUX8;
      bank_sel = 1'b0;
      ram_wr = '0;
      repeat (4) @(negedge core_clk);
      rst_n = 1'b1;
      for (int c = 0; c < BASE_COLS; c++)
         wr(0, 6'(c), 8'h00);
      wr(0, 0, 8'hA5);
      wr(0, 43, 8'h5A);
      ram_wr.en = 1'b0;
      run(MODE_MUX8, 0, 8, 0, 8'hA5);
      run(MODE_MUX8, 0, 8, 43, 8'h5A);
      run(MODE_MUX6, 0, 6, 0, 8'h25);
      wr(0, 44, 8'h3C);
      wr(0, 45, 8'h03);
      ram_wr.en = 1'b0;
      run(MODE_MUX6, 0, 6, 44, 8'h3C);
      run(MODE_MUX6, 0, 6, 45, 8'h03);
      chk({7'h0, pins_seg}, 8'h01);
      run(MODE_MUX8, 0, 8, 0, 8'hA5);
      chk(pix[44], 8'h80);
      chk(pix[45], 8'h40);
      wr(0, 44, 8'hFF);
      ram_wr.en = 1'b0;
      run(MODE_MUX6, 0, 6, 44, 8'h3C);
      run(MODE_MUX4, 0, 4, 0, 8'h05);
      wr(0, 1, 8'h66);
      wr(1, 1, 8'h99);
      ram_wr.en = 1'b0;
      run(MODE_MUX4, 0, 4, 1, 8'h06);
      run(MODE_MUX4, 1, 4, 1, 8'h09);
      run(MODE_MUX2, 0, 2, 0, 8'h01);
      wr(1, 2, 8'h33);
      ram_wr.en = 1'b0;
      run(MODE_MUX2, 1, 2, 2, 8'h03);
      run(MODE_STATIC, 0, 1, 0, 8'h01);
      run(MODE_STATIC, 1, 1, 0, 8'h00);
      test_done();
   end
endmodule : test_lcd_plane_output_mapper
